/* rtl/nvsc_host.sv */
`timescale 1ns/1ps
`include "nvsc_consts.svh"
// host controller driving the nonvolatile sram pins
module nvsc_host (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // request side
   input wire logic req_valid,
   input wire nvsc_pkg::nvsc_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output nvsc_pkg::nvsc_rsp_t rsp,
   // memory control pins
   output nvsc_pkg::nvsc_pins_t pins,
   // data pins
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe,
   // store/busy open-drain line
   input wire logic hw_store_busy_n_in,
   output logic hw_store_busy_n_out,
   output logic hw_store_busy_n_oe
);
   import nvsc_pkg::*;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_SETUP = 7'b0000010,
      ST_PULSE = 7'b0000100,
      ST_HOLD = 7'b0001000,
      ST_HSREQ = 7'b0010000,
      ST_HSWAIT = 7'b0100000,
      ST_NVWAIT = 7'b1000000
   } nvsc_state_t;

   nvsc_state_t state_reg;
   nvsc_req_t cur_reg;
   logic [2:0] step_reg;
   logic [1:0] busy_sync_reg;
   logic busy_seen_reg;
   logic busy_low;
   logic tmr_load;
   logic [`NVSC_CNT_W-1:0] tmr_val;
   logic tmr_done;
   logic [12:0] seq_addr;
   logic is_seq;
   logic last_step;

   // two-flop synchroniser on the store/busy line
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_sync_reg <= 2'h3;
      end else begin
         busy_sync_reg <= {busy_sync_reg[0], hw_store_busy_n_in};
      end
   end
   assign busy_low = !busy_sync_reg[1];

   assign is_seq = (cur_reg.op == NVSC_OP_SW_STORE) || (cur_reg.op == NVSC_OP_SW_RECALL);
   assign last_step = !is_seq || (step_reg == 3'h5);

   always_comb begin
      unique case (step_reg)
         3'h0: seq_addr = `NVSC_SEQ_A0;
         3'h1: seq_addr = `NVSC_SEQ_A1;
         3'h2: seq_addr = `NVSC_SEQ_A2;
         3'h3: seq_addr = `NVSC_SEQ_A3;
         3'h4: seq_addr = `NVSC_SEQ_A4;
         default: seq_addr = (cur_reg.op == NVSC_OP_SW_STORE) ?
                             `NVSC_SEQ_STORE : `NVSC_SEQ_RECALL;
      endcase
   end

   // timer load per state transition
   always_comb begin
      tmr_load = 1'b0;
      tmr_val = '0;
      unique case (state_reg)
         ST_IDLE: begin
            if (req_valid) begin
               tmr_load = 1'b1;
               tmr_val = (req.op == NVSC_OP_HW_STORE) ?
                         `NVSC_CNT_W'(`NVSC_T_HSREQ_CYC) : `NVSC_CNT_W'(`NVSC_T_SETUP_CYC);
            end
         end
         ST_SETUP: begin
            tmr_load = tmr_done;
            tmr_val = `NVSC_CNT_W'(`NVSC_T_PULSE_CYC);
         end
         ST_PULSE: begin
            tmr_load = tmr_done;
            tmr_val = `NVSC_CNT_W'(`NVSC_T_HOLD_CYC);
         end
         ST_HOLD: begin
            tmr_load = tmr_done;
            tmr_val = last_step ? (cur_reg.op == NVSC_OP_SW_RECALL ?
                      `NVSC_CNT_W'(`NVSC_T_RECALL_CYC) : `NVSC_CNT_W'(`NVSC_T_STORE_CYC)) :
                      `NVSC_CNT_W'(`NVSC_T_SETUP_CYC);
         end
         ST_HSREQ: begin
            tmr_load = tmr_done;
            tmr_val = `NVSC_CNT_W'(`NVSC_T_STORE_CYC);
         end
         ST_HSWAIT: begin
            tmr_load = tmr_done;
            tmr_val = `NVSC_CNT_W'(`NVSC_T_RECOVER_CYC);
         end
         ST_NVWAIT: begin
            tmr_load = 1'b0;
         end
      endcase
   end

   nvsc_timer u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(tmr_load),
      .load_val(tmr_val),
      .done(tmr_done)
   );

   // main sequencer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cur_reg <= '0;
         step_reg <= 3'h0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (req_valid) begin
                  cur_reg <= req;
                  step_reg <= 3'h0;
                  state_reg <= (req.op == NVSC_OP_HW_STORE) ? ST_HSREQ : ST_SETUP;
               end
            end
            ST_SETUP: if (tmr_done) begin
               state_reg <= ST_PULSE;
            end
            ST_PULSE: if (tmr_done) begin
               state_reg <= ST_HOLD;
            end
            ST_HOLD: if (tmr_done) begin
               if (!is_seq) begin
                  state_reg <= ST_IDLE;
               end else if (last_step) begin
                  state_reg <= ST_NVWAIT;
               end else begin
                  step_reg <= step_reg + 3'h1;
                  state_reg <= ST_SETUP;
               end
            end
            ST_HSREQ: if (tmr_done) begin
               state_reg <= ST_HSWAIT;
            end
            ST_HSWAIT: if (tmr_done) begin
               state_reg <= ST_NVWAIT;
            end
            ST_NVWAIT: if (tmr_done && !busy_low) begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // pin drive: chip select framed reads and writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins <= '{chip_sel_n: 1'b1, wr_n: 1'b1, out_en_n: 1'b1, addr: '0};
         dq_out <= '0;
         dq_oe <= 1'b0;
      end else begin
         pins.chip_sel_n <= !(tmr_load && state_reg == ST_SETUP);
         if (state_reg == ST_PULSE && !tmr_done) begin
            pins.chip_sel_n <= 1'b0;
         end
         pins.wr_n <= !((state_reg == ST_SETUP || state_reg == ST_PULSE) &&
                        cur_reg.op == NVSC_OP_WRITE);
         pins.addr <= is_seq ? seq_addr : cur_reg.addr;
         pins.out_en_n <= !((state_reg == ST_SETUP || state_reg == ST_PULSE) &&
                            cur_reg.op == NVSC_OP_READ);
         dq_out <= cur_reg.data;
         dq_oe <= (state_reg == ST_SETUP || state_reg == ST_PULSE || state_reg == ST_HOLD)
                  && cur_reg.op == NVSC_OP_WRITE;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hw_store_busy_n_oe <= 1'b0;
      end else begin
         hw_store_busy_n_oe <= (state_reg == ST_IDLE && req_valid && req.op == NVSC_OP_HW_STORE)
                               || (state_reg == ST_HSREQ && !tmr_done);
      end
   end
   assign hw_store_busy_n_out = 1'b0;

   // answers: read data, and whether the device signalled busy
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
         busy_seen_reg <= 1'b0;
         req_ready <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         req_ready <= (state_reg == ST_IDLE) && !req_valid;
         if (state_reg == ST_IDLE) begin
            busy_seen_reg <= 1'b0;
         end else if (busy_low) begin
            busy_seen_reg <= 1'b1;
         end
         if (state_reg == ST_PULSE && tmr_done && cur_reg.op == NVSC_OP_READ) begin
            rsp.data <= dq_in;
         end
         if ((state_reg == ST_HOLD && tmr_done && !is_seq) ||
             (state_reg == ST_NVWAIT && tmr_done && !busy_low)) begin
            rsp_valid <= 1'b1;
            rsp.busy_seen <= busy_seen_reg || busy_low;
         end
      end
   end

   // write never overlaps the host driving the store line low
   a_write_store_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !pins.wr_n |-> !hw_store_busy_n_oe) else $error("write while store line driven");
   a_seq_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      is_seq && state_reg != ST_IDLE |-> pins.wr_n) else $error("write in sequence");
   // request pulse at least one cycle then released
   a_hsreq_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(hw_store_busy_n_oe) |-> ##[1:4] !hw_store_busy_n_oe) else $error("bad pulse");
   // sequence access framed by chip select
   a_seq_framed: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(pins.chip_sel_n) && is_seq |-> pins.addr == $past(seq_addr))
      else $error("sequence address wrong");
   a_addr_stable_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !pins.chip_sel_n |-> $stable(pins.addr)) else $error("address moved while selected");
   c_read: cover property (@(posedge sys_clk) rsp_valid && cur_reg.op == NVSC_OP_READ);
   c_sw_store: cover property (@(posedge sys_clk) rsp_valid && cur_reg.op == NVSC_OP_SW_STORE);
   c_hw_store: cover property (@(posedge sys_clk) rsp_valid && cur_reg.op == NVSC_OP_HW_STORE);
endmodule

/* rtl/nvsc_consts.svh */
// Overview of operation
// - hold store/busy line high through every ordinary write cycle.
// - six reads 0000,1555,0AAA,1FFF,10F0 then 0F0F store or 0F0E recall.
// - write strobe stays high during all six sequence accesses.
// - host holds store line low at least 15 ns to request a store.
// - each sequence read is framed by chip select, address taken on its fall.
`ifndef NVSC_CONSTS_SVH
`define NVSC_CONSTS_SVH
`define NVSC_CLK_NS 20
`define NVSC_ADDR_W 13
`define NVSC_DATA_W 8
`define NVSC_SEQ_A0 13'h0000
`define NVSC_SEQ_A1 13'h1555
`define NVSC_SEQ_A2 13'h0aaa
`define NVSC_SEQ_A3 13'h1fff
`define NVSC_SEQ_A4 13'h10f0
`define NVSC_SEQ_STORE 13'h0f0f
`define NVSC_SEQ_RECALL 13'h0f0e
// access timing: setup, strobe width, hold in ns
`define NVSC_T_SETUP_NS 20
`define NVSC_T_SETUP_CYC ((`NVSC_T_SETUP_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_T_PULSE_NS 60
`define NVSC_T_PULSE_CYC ((`NVSC_T_PULSE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_T_HOLD_NS 20
`define NVSC_T_HOLD_CYC ((`NVSC_T_HOLD_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
// hardware store request pulse, least 15 ns
`define NVSC_T_HSREQ_NS 15
`define NVSC_T_HSREQ_CYC ((`NVSC_T_HSREQ_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
// busy must appear within 300 ns
`define NVSC_T_BUSY_NS 300
`define NVSC_T_BUSY_CYC (`NVSC_T_BUSY_NS / `NVSC_CLK_NS)
// store time 10 ms, recall 20 us, recovery 700 ns
`define NVSC_T_STORE_NS 10000000
`define NVSC_T_STORE_CYC (`NVSC_T_STORE_NS / `NVSC_CLK_NS)
`define NVSC_T_RECALL_NS 20000
`define NVSC_T_RECALL_CYC (`NVSC_T_RECALL_NS / `NVSC_CLK_NS)
`define NVSC_T_RECOVER_NS 700
`define NVSC_T_RECOVER_CYC ((`NVSC_T_RECOVER_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_CNT_W 24
`endif

/* rtl/nvsc_pkg.sv */
package nvsc_pkg;
   typedef enum logic [2:0] {
      NVSC_OP_READ = 3'h0,
      NVSC_OP_WRITE = 3'h1,
      NVSC_OP_SW_STORE = 3'h2,
      NVSC_OP_SW_RECALL = 3'h3,
      NVSC_OP_HW_STORE = 3'h4
   } nvsc_op_t;
   typedef struct packed {
      nvsc_op_t op;
      logic [12:0] addr;
      logic [7:0] data;
   } nvsc_req_t;
   typedef struct packed {
      logic [7:0] data;
      logic busy_seen;
   } nvsc_rsp_t;
   typedef struct packed {
      logic chip_sel_n;
      logic wr_n;
      logic out_en_n;
      logic [12:0] addr;
   } nvsc_pins_t;
endpackage

/* rtl/nvsc_timer.sv */
`timescale 1ns/1ps
`include "nvsc_consts.svh"
// loadable down counter, done is high while the count is zero
module nvsc_timer (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [`NVSC_CNT_W-1:0] load_val,
   // status
   output logic done
);
   logic [`NVSC_CNT_W-1:0] cnt_reg;

   // count down to zero after each load
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (load) begin
         cnt_reg <= load_val;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign done = (cnt_reg == '0);
endmodule

/* verification/nvsc_dev_model.sv */
`timescale 1ns/1ps
// behavioural nonvolatile sram seen from its pins
module nvsc_dev_model #(
   parameter int T_RECALL_NS = 20000,
   parameter int T_STORE_NS = 10000000
) (
   // control pins
   input wire logic chip_sel_n,
   input wire logic wr_n,
   input wire logic out_en_n,
   input wire logic [12:0] addr,
   // data pins
   input wire logic [7:0] dq_host,
   output logic [7:0] dq_dev,
   output logic dq_dev_oe,
   // store/busy line
   input wire logic hw_store_busy_n,
   output logic busy_pull
);
   logic [7:0] sram [0:8191];
   logic [7:0] nv [0:8191];
   logic [12:0] seq_tab [0:4] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
   logic [7:0] last_dq = 8'h00;
   logic written = 1'b0;
   logic inhibit = 1'b0;
   logic wr_at_fall = 1'b0;
   logic wr_active;
   int seq_pos = 0;
   initial begin
      busy_pull = 1'b0;
      for (int i = 0; i < 8192; i++) begin
         nv[i] = 8'(i) ^ 8'h3c;
         sram[i] = nv[i];
      end
   end
   // transfer time, device shut off meanwhile
   task automatic nv_cycle(input logic store);
      inhibit = 1'b1;
      #(store ? T_STORE_NS : T_RECALL_NS);
      for (int i = 0; i < 8192; i++) begin
         if (store) nv[i] = sram[i];
         else sram[i] = nv[i];
      end
      written = 1'b0;
      inhibit = 1'b0;
   endtask
   always @(negedge chip_sel_n) begin
      wr_at_fall = !wr_n;
      if (inhibit || !hw_store_busy_n || !wr_n) begin
         seq_pos = 0;
      end else if (seq_pos == 5 && addr inside {13'h0f0f, 13'h0f0e}) begin
         seq_pos = 0;
         nv_cycle(addr == 13'h0f0f);
      end else if (seq_pos < 5 && addr == seq_tab[seq_pos]) begin
         seq_pos++;
      end else begin
         seq_pos = (addr == 13'h0000) ? 1 : 0;
      end
   end
   // write taken at end of strobe
   assign wr_active = !chip_sel_n && !wr_n && hw_store_busy_n && !inhibit;
   always @(negedge wr_active) begin
      if (!inhibit && hw_store_busy_n) begin
         sram[addr] = dq_host;
         written = 1'b1;
      end
   end
   // data driven only on a clean read
   assign dq_dev_oe = !chip_sel_n && wr_n && !out_en_n && hw_store_busy_n && !inhibit
                      && !wr_at_fall;
   assign dq_dev = dq_dev_oe ? sram[addr] : ~last_dq;
   always @(negedge dq_dev_oe) last_dq = sram[addr];
   // hardware store, busy pulled low meanwhile
   always @(negedge hw_store_busy_n) begin
      if (!busy_pull) begin
         #100;
         busy_pull = 1'b1;
         #900;
         if (written) nv_cycle(1'b1);
         inhibit = 1'b1;
         busy_pull = 1'b0;
         wait (hw_store_busy_n);
         #500;
         inhibit = 1'b0;
      end
   end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import nvsc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   nvsc_req_t req = '0;
   logic req_ready, rsp_valid, dq_oe, dq_dev_oe, busy_oe, busy_out, busy_pull;
   nvsc_rsp_t rsp, r;
   nvsc_pins_t pins;
   logic [7:0] dq_out, dq_dev;
   wire logic [7:0] dq_line;
   wire logic busy_line;
   int fail_count = 0;
   int total_checks = 0;
   int wr_busy_low = 0;
   int clash = 0;
   int wr_fall = 0;
   logic [12:0] seen_addr [$];
   logic [12:0] seq_exp [0:5] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0, 13'h0f0e};
   // clock, pull-up on the busy line, data line resolution
   always #10 sys_clk = ~sys_clk;
   assign busy_line = !((busy_oe && !busy_out) || busy_pull);
   assign dq_line = dq_oe ? dq_out : dq_dev;
   nvsc_host DUT (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
      .dq_in(dq_line), .dq_out(dq_out), .dq_oe(dq_oe), .hw_store_busy_n_in(busy_line),
      .hw_store_busy_n_out(busy_out), .hw_store_busy_n_oe(busy_oe));
   nvsc_dev_model dev (.chip_sel_n(pins.chip_sel_n), .wr_n(pins.wr_n),
      .out_en_n(pins.out_en_n), .addr(pins.addr), .dq_host(dq_line), .dq_dev(dq_dev),
      .dq_dev_oe(dq_dev_oe), .hw_store_busy_n(busy_line), .busy_pull(busy_pull));
   // pin watchers
   always @(negedge sys_clk) begin
      if (!pins.chip_sel_n && !pins.wr_n && !busy_line) wr_busy_low++;
      if (dq_oe && dq_dev_oe) clash++;
   end
   always @(negedge pins.chip_sel_n) begin
      seen_addr.push_back(pins.addr);
      if (!pins.wr_n) wr_fall++;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_op(input nvsc_op_t op, input logic [12:0] a, input logic [7:0] d,
                        input int limit, output nvsc_rsp_t res);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      check("req_ready", 16'(req_ready), 16'h1);
      req = '{op: op, addr: a, data: d};
      req_valid = 1'b1;
      @(negedge sys_clk);
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < limit) begin
         @(negedge sys_clk);
         n++;
      end
      check("rsp_valid", 16'(rsp_valid), 16'h1);
      res = rsp;
   endtask
   task automatic t_reset();
      repeat (20) @(negedge sys_clk);
      check("idle pins", 16'({pins.chip_sel_n, pins.wr_n, dq_oe, busy_oe, rsp_valid}),
            16'h18);
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      check("req_ready", 16'(req_ready), 16'h1);
   endtask
   // hardware store after a write; host still busy 20 cycles after the request
   task automatic t_hw_store();
      int oe_cyc;
      oe_cyc = 0;
      do_op(NVSC_OP_WRITE, 13'h0789, 8'hc3, 20, r);
      @(negedge sys_clk);
      req = '{op: NVSC_OP_HW_STORE, addr: 13'h0000, data: 8'h00};
      req_valid = 1'b1;
      @(negedge sys_clk);
      req_valid = 1'b0;
      repeat (20) begin
         if (busy_oe) oe_cyc++;
         @(negedge sys_clk);
      end
      check("store pulse long", 16'(oe_cyc >= 1), 16'h1);
      check("busy from device", 16'(busy_line), 16'h0);
      check("held off while busy", 16'({req_ready, pins.chip_sel_n}), 16'h1);
      check("write with line low", 16'(wr_busy_low), 16'h0);
   endtask
   task automatic t_write_read();
      logic [12:0] a [0:2] = '{13'h0000, 13'h0123, 13'h1fff};
      for (int i = 0; i < 3; i++) begin
         do_op(NVSC_OP_WRITE, a[i], 8'h5a + 8'(i), 20, r);
      end
      for (int i = 0; i < 3; i++) begin
         do_op(NVSC_OP_READ, a[i], 8'h00, 20, r);
         check("read back", 16'(r.data), 16'(8'h5a + 8'(i)));
      end
      check("write with line low", 16'(wr_busy_low), 16'h0);
      check("bus clash", 16'(clash), 16'h0);
   endtask
   task automatic t_sw_recall();
      do_op(NVSC_OP_READ, 13'h0456, 8'h00, 20, r);
      check("power-up byte", 16'(r.data), 16'(8'h56 ^ 8'h3c));
      do_op(NVSC_OP_WRITE, 13'h0456, 8'ha5, 20, r);
      seen_addr.delete();
      wr_fall = 0;
      do_op(NVSC_OP_SW_RECALL, 13'h0000, 8'h00, 3000, r);
      check("busy seen", 16'(r.busy_seen), 16'h0);
      check("sequence length", 16'(seen_addr.size()), 16'h6);
      for (int i = 0; i < 6; i++) begin
         check("sequence addr", 16'(seen_addr[i]), 16'(seq_exp[i]));
      end
      check("strobe in sequence", 16'(wr_fall), 16'h0);
      do_op(NVSC_OP_READ, 13'h0456, 8'h00, 20, r);
      check("recalled byte", 16'(r.data), 16'(8'h56 ^ 8'h3c));
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #400000;
      fail_count++;
      $display("watchdog expired");
      tally_and_finish();
   end
   // main sequence
   initial begin
      t_reset();
      t_write_read();
      t_sw_recall();
      t_hw_store();
      tally_and_finish();
   end
endmodule
